// ### core/par_sram_port.sv
// Byte-parallel SRAM port; link logic on the host strobe domain
`timescale 1ns/10ps
module par_sram_port (
	// Core clock and reset
	input  wire logic                       core_clk_in,
	input  wire logic                       rst_n_in,
	// Link clock, free running strobe sample clock from the host side
	input  wire logic                       link_clk_in,
	// Host pins
	input  wire logic                       parallel_select_n_in,
	input  wire logic                       serial_select_n_in,
	input  wire logic                       write_strobe_n_in,
	input  wire logic                       read_strobe_n_in,
	input  wire logic [par_sram_pkg::DATA_W-1:0] data_in,
	output logic [par_sram_pkg::DATA_W-1:0] data_out,
	output logic                            data_oe_out,
	// Chain position of this chip
	input  wire logic [par_sram_pkg::CHIP_W-1:0] chip_id_in,
	// Core side status
	output logic                            busy_out
);
	import par_sram_pkg::*;

	logic [DATA_W-1:0] mem [0:DEPTH-1];

	// Two-stage synchronisers on link clock
	logic [1:0] cs_s_r, wr_s_r, rd_s_r, ss_s_r;
	logic [DATA_W-1:0] din_s1_r, din_s2_r;
	logic [CHIP_W-1:0] chip_s1_r, chip_s2_r;
	always_ff @(posedge link_clk_in) begin
		cs_s_r   <= {cs_s_r[0], parallel_select_n_in};
		wr_s_r   <= {wr_s_r[0], write_strobe_n_in};
		rd_s_r   <= {rd_s_r[0], read_strobe_n_in};
		ss_s_r   <= {ss_s_r[0], serial_select_n_in};
		din_s1_r <= data_in;
		din_s2_r <= din_s1_r;
		// Static strap, but still a pin, so it is synchronised too
		chip_s1_r <= chip_id_in;
		chip_s2_r <= chip_s1_r;
	end

	// Reset crosses as a level into the link domain
	logic [1:0] lrst_r;
	always_ff @(posedge link_clk_in) begin
		lrst_r <= {lrst_r[0], rst_n_in};
	end
	wire link_rst_n = lrst_r[1];

	logic wr_d_r, rd_d_r;
	always_ff @(posedge link_clk_in) begin
		wr_d_r <= wr_s_r[1];
		rd_d_r <= rd_s_r[1];
	end

	// Byte taken on rising edge of each strobe
	wire sel     = ~cs_s_r[1] & ss_s_r[1];
	wire wr_edge = sel & wr_s_r[1] & ~wr_d_r;
	wire rd_edge = sel & rd_s_r[1] & ~rd_d_r;

	port_state_type    state_r, state_nxt;
	logic [1:0]        cnt_r;
	logic [ADDR_W-1:0] addr_r;
	logic [CHIP_W-1:0] chip_r;
	logic              is_rd_r;
	logic              first_r;
	logic [DATA_W-1:0] dout_r;
	logic              oe_r;
	logic [DATA_W-1:0] hold_r;
	logic              hold_v_r;

	// Chip field sits in the top address byte above the 17 address bits
	wire              mine      = (chip_r == chip_s2_r);
	wire              at_top    = (addr_r == ADDR_TOP);
	wire [ADDR_W-1:0] addr_inc  = at_top ? ADDR_ZERO : addr_r + 1'b1;
	wire [CHIP_W-1:0] chip_inc  = at_top ? chip_r + 1'b1 : chip_r;
	wire              last_addr = (cnt_r == ADDR_BYTES - 2'h1);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE:   if (wr_edge) state_nxt = ST_ADDR;
			ST_ADDR:   if (wr_edge && last_addr)
				state_nxt = is_rd_r ? ST_READ : ST_WRITE;
			ST_READ:   state_nxt = ST_READ;
			ST_WRITE:  state_nxt = ST_WRITE;
			ST_IGNORE: state_nxt = ST_IGNORE;
		endcase
		if (!sel) state_nxt = ST_IDLE;
	end

	always_ff @(posedge link_clk_in) begin
		if (!link_rst_n) begin
			state_r  <= ST_IDLE;
			cnt_r    <= 2'h0;
			addr_r   <= ADDR_ZERO;
			chip_r   <= '0;
			is_rd_r  <= 1'b0;
			first_r  <= 1'b0;
			dout_r   <= '0;
			oe_r     <= 1'b0;
			hold_v_r <= 1'b0;
			hold_r   <= '0;
		end else begin
			state_r <= state_nxt;
			if (!sel) begin
				oe_r     <= 1'b0;
				hold_v_r <= 1'b0;
			end
			if (state_r == ST_IDLE && wr_edge) begin
				cnt_r   <= 2'h0;
				is_rd_r <= (din_s2_r == OP_READ);
				if (din_s2_r != OP_READ && din_s2_r != OP_WRITE)
					state_r <= ST_IGNORE;
			end
			if (state_r == ST_ADDR && wr_edge) begin
				cnt_r <= cnt_r + 2'h1;
				unique case (cnt_r)
					2'h0: chip_r <= din_s2_r[CHIP_W:1];
					2'h1: addr_r[15:8] <= din_s2_r;
					default: addr_r[7:0] <= din_s2_r;
				endcase
				if (cnt_r == 2'h0) addr_r[ADDR_W-1] <= din_s2_r[0];
				first_r <= 1'b1;
			end
			// Read: data valid from the second cycle after the last address byte
			if (state_r == ST_READ && sel) begin
				oe_r <= mine;
				if (first_r || rd_edge) begin
					dout_r  <= mem[addr_r];
					first_r <= 1'b0;
					if (rd_edge) begin
						addr_r <= addr_inc;
						chip_r <= chip_inc;
						dout_r <= mem[addr_inc];
					end
				end
			end
			// Write: each byte stored on the next strobe, so a dummy
			// byte is needed to commit the last one
			if (state_r == ST_WRITE && wr_edge) begin
				hold_r   <= din_s2_r;
				hold_v_r <= 1'b1;
				if (hold_v_r) begin
					addr_r <= addr_inc;
					chip_r <= chip_inc;
				end
			end
		end
	end

	wire do_store = state_r == ST_WRITE && wr_edge && hold_v_r && mine;
	always_ff @(posedge link_clk_in) begin
		if (do_store) mem[addr_r] <= hold_r;
	end

	// Busy level crosses to the core domain
	logic busy_l_r;
	logic [1:0] busy_s_r;
	always_ff @(posedge link_clk_in) begin
		busy_l_r <= (state_r != ST_IDLE) & link_rst_n;
	end
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			busy_s_r <= 2'h0;
			busy_out <= 1'b0;
		end else begin
			busy_s_r <= {busy_s_r[0], busy_l_r};
			busy_out <= busy_s_r[1];
		end
	end

	assign data_out    = dout_r;
	assign data_oe_out = oe_r;

	property p_float_on_release;
		@(posedge link_clk_in) disable iff (!link_rst_n)
		!sel |=> !oe_r;
	endproperty
	a_float_on_release: assert property (p_float_on_release)
		else $error("data pins driven after select released");

	property p_idle_on_release;
		@(posedge link_clk_in) disable iff (!link_rst_n)
		!sel |=> state_r == ST_IDLE;
	endproperty
	a_idle_on_release: assert property (p_idle_on_release)
		else $error("transaction outlived select");

	property p_wrap;
		@(posedge link_clk_in) disable iff (!link_rst_n)
		(state_r == ST_READ && sel && rd_edge && at_top && !first_r)
		|=> addr_r == ADDR_ZERO;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("address did not wrap");

	sequence s_read_addr_done;
		state_r == ST_ADDR && wr_edge && last_addr && is_rd_r;
	endsequence

	sequence s_read_step;
		state_r == ST_READ && sel && rd_edge && !first_r;
	endsequence

	sequence s_write_step;
		state_r == ST_WRITE && wr_edge;
	endsequence

	property p_read_lead;
		@(posedge link_clk_in) disable iff (!link_rst_n)
		s_read_addr_done ##1 (sel && mine) |=> oe_r && !first_r;
	endproperty
	a_read_lead: assert property (p_read_lead)
		else $error("read data not driven after the address");

	// First byte is only held, so the pointer must not move yet
	property p_write_first;
		@(posedge link_clk_in) disable iff (!link_rst_n)
		s_write_step ##0 !hold_v_r |=> hold_v_r && $stable(addr_r);
	endproperty
	a_write_first: assert property (p_write_first)
		else $error("first write byte moved the pointer");

	property p_write_advance;
		@(posedge link_clk_in) disable iff (!link_rst_n)
		s_write_step ##0 hold_v_r |=> addr_r == $past(addr_r) + 1'b1;
	endproperty
	a_write_advance: assert property (p_write_advance)
		else $error("write pointer did not advance");

	property p_chain_step;
		@(posedge link_clk_in) disable iff (!link_rst_n)
		s_read_step ##0 at_top |=> chip_r == $past(chip_r) + 1'b1;
	endproperty
	a_chain_step: assert property (p_chain_step)
		else $error("read did not pass on to the next chip");
endmodule : par_sram_port

// ### core/par_sram_pkg.sv
// Constants and state type for the byte-parallel SRAM port
package par_sram_pkg;
	localparam int         ADDR_W      = 17;
	localparam int         DATA_W      = 8;
	localparam int         DEPTH       = 131072;
	localparam int         CHIP_W      = 7;
	localparam logic [7:0] OP_READ     = 8'h03;
	localparam logic [7:0] OP_WRITE    = 8'h02;
	localparam logic [ADDR_W-1:0] ADDR_TOP  = 17'h1FFFF;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 17'h00000;
	localparam logic [1:0] ADDR_BYTES  = 2'h3;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_READ,
		ST_WRITE,
		ST_IGNORE
	} port_state_type;
endpackage : par_sram_pkg

// ### sim/host_model.sv
// Host side model driving the parallel pins
`timescale 1ns/10ps
module host_model (
	// Clock and read back pins
	input  wire logic       core_clk_in,
	input  wire logic [7:0] rd_data_in,
	// Pins to the port
	output logic            select_n_out,
	output logic            wr_n_out,
	output logic            rd_n_out,
	output logic [7:0]      wr_data_out
);
	initial begin
		select_n_out = 1'b1;
		wr_n_out = 1'b1;
		rd_n_out = 1'b1;
		wr_data_out = 8'h00;
	end
	// Half strobe of 8 core cycles, over 5 link clocks
	task automatic hold();
		repeat (8) @(negedge core_clk_in);
	endtask : hold
	task automatic put(input logic [7:0] b);
		wr_data_out = b;
		wr_n_out = 1'b0;
		hold();
		wr_n_out = 1'b1;
		hold();
	endtask : put
	task automatic get(output logic [7:0] b);
		rd_n_out = 1'b0;
		hold();
		b = rd_data_in;
		rd_n_out = 1'b1;
		hold();
	endtask : get
	task automatic start(input logic [7:0] op, input logic [16:0] a);
		select_n_out = 1'b0;
		hold();
		put(op);
		put({7'h00, a[16]});
		put(a[15:8]);
		put(a[7:0]);
	endtask : start
	task automatic stop();
		select_n_out = 1'b1;
		hold();
	endtask : stop
endmodule : host_model

// ### sim/tb.sv
// Self-checking bench for the parallel port
`timescale 1ns/10ps
module tb;
	import par_sram_pkg::*;
	logic       clk, lclk, rst_n, ser_n, sel_n, wr_n, rd_n, oe, busy;
	logic [7:0] din, dout, seen, rs, b;
	logic [7:0] q[$];
	logic [6:0] chip;
	int         bad_count, comparisons, cyc;
	string      what;
	event       got;
	par_sram_port i_dut (.core_clk_in(clk), .rst_n_in(rst_n),
		.link_clk_in(lclk), .parallel_select_n_in(sel_n),
		.serial_select_n_in(ser_n), .write_strobe_n_in(wr_n),
		.read_strobe_n_in(rd_n), .data_in(din), .data_out(dout),
		.data_oe_out(oe), .chip_id_in(chip), .busy_out(busy));
	host_model h (.core_clk_in(clk), .rd_data_in(dout),
		.select_n_out(sel_n), .wr_n_out(wr_n), .rd_n_out(rd_n),
		.wr_data_out(din));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		lclk = 1'b0;
		#7;
		forever #15 lclk = ~lclk;
	end
	function automatic logic [7:0] xs(input logic [7:0] s);
		s ^= s << 3;
		s ^= s >> 5;
		s ^= s << 1;
		return s;
	endfunction : xs
	task automatic final_report();
		$display("Checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : final_report
	task automatic note(input string w, input logic [7:0] e, v);
		q.push_back(e);
		what = w;
		seen = v;
		->got;
		@(negedge clk);
	endtask : note
	always @(got) begin
		comparisons++;
		if (seen !== q[0])
			$display("Error %s exp %h got %h", what, q[0], seen);
		if (seen !== q[0]) bad_count++;
		void'(q.pop_front());
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
	task automatic wr_rd(input logic [16:0] a, input int n);
		logic [7:0] d[$];
		h.start(OP_WRITE, a);
		for (int i = 0; i < n; i++) begin
			rs = xs(rs);
			d.push_back(rs);
			h.put(rs);
		end
		h.put(8'h00);
		h.stop();
		h.start(OP_READ, a);
		for (int i = 0; i < n; i++) begin
			h.get(b);
			note("read byte", d[i], b);
		end
		note("oe in read", {7'h00, (a + n) <= ADDR_TOP}, {7'h00, oe});
		note("busy in read", 8'h01, {7'h00, busy});
		h.stop();
		repeat (8) @(negedge clk);
		note("oe after end", 8'h00, {7'h00, oe});
		note("busy after end", 8'h00, {7'h00, busy});
		$display("Test done at %h", a);
	endtask : wr_rd
	task automatic refused(input logic [7:0] op, input logic s,
		input logic [6:0] c);
		@(negedge clk);
		ser_n = s;
		chip = c;
		h.start(op, 17'h00000);
		h.get(b);
		note("oe refused", 8'h00, {7'h00, oe});
		h.stop();
		ser_n = 1'b1;
		chip = 7'h00;
		$display("Test done refusal %h", op);
	endtask : refused
	initial begin
		rst_n = 1'b0;
		ser_n = 1'b1;
		chip = 7'h00;
		rs = 8'h61;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		note("oe idle", 8'h00, {7'h00, oe});
		wr_rd(ADDR_ZERO, 4);
		wr_rd(17'h1FFF8, 8);
		rs = xs(rs);
		wr_rd({7'h00, rs, 2'h0}, 12);
		refused(8'h05, 1'b1, 7'h00);
		refused(OP_READ, 1'b0, 7'h00);
		refused(OP_READ, 1'b1, 7'h01);
		wr_rd(17'h00100, 4);
		final_report();
	end
endmodule : tb
